// ---- rcs_sequencer.v ----
// relay close sequencer for a six-section switching module
// assumes synchronous trigger inputs and a single-cycle register port
//
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_sequencer
#(
   parameter [31:0] ENC_DLY_TICKS = `RCS_ENC_DLY_TICKS,
   parameter [31:0] ENC_WID_TICKS = `RCS_ENC_WID_TICKS
)
(
   // clock and reset
   input  wire         clk_i,
   input  wire         rst_i,
   // register port
   input  wire [7:0]   addr_i,
   input  wire [31:0]  wdata_i,
   input  wire         wstb_i,
   input  wire         rstb_i,
   output reg  [31:0]  rdata_o,
   // backplane trigger lines, open drain
   input  wire [7:0]   ttl_i,
   output wire [7:0]   ttl_o,
   output reg  [7:0]   ttl_oe_n_o,
   // relay drives and encode strobes
   output wire [239:0] relay_on_o,
   output reg  [5:0]   enc_lo_n_o,
   output reg  [5:0]   enc_hi_n_o
);

   localparam [8:0] S_IDLE  = 9'h001;
   localparam [8:0] S_TDLY  = 9'h002;
   localparam [8:0] S_OPEN  = 9'h004;
   localparam [8:0] S_ODW   = 9'h008;
   localparam [8:0] S_CLOSE = 9'h010;
   localparam [8:0] S_CDW   = 9'h020;
   localparam [8:0] S_TRIG  = 9'h040;
   localparam [8:0] S_ENCW  = 9'h080;
   localparam [8:0] S_ENCL  = 9'h100;

   // ========================================================================
   // registers
   reg  [8:0]   state_reg;
   reg  [8:0]   state_next;
   reg  [255:0] relay_reg;
   reg  [255:0] mask_reg;
   reg  [255:0] open_reg;
   reg  [255:0] close_reg;
   reg  [5:0]   mode_reg;
   reg  [11:0]  conf_reg;
   reg  [5:0]   join_reg;
   reg  [31:0]  open_dwell_reg;
   reg  [31:0]  close_dwell_reg;
   reg  [31:0]  trig_delay_reg;
   reg  [7:0]   ttl_en_reg;
   reg  [2:0]   scan_sect_reg;
   reg  [5:0]   scan_first_reg;
   reg  [5:0]   scan_last_reg;
   reg  [2:0]   scan_src_reg;
   reg  [2:0]   chan_sect_reg;
   reg  [5:0]   chan_idx_reg;
   reg  [2:0]   word_idx_reg;
   reg          armed_reg;
   reg          first_reg;
   reg  [5:0]   scan_cur_reg;
   reg  [5:0]   scan_nxt_reg;
   reg  [7:0]   ttl_prev_reg;
   reg  [5:0]   enc_lo_reg;
   reg  [5:0]   enc_hi_reg;

   wire [255:0] valid_all;
   wire [255:0] scan_grp_all;
   wire [255:0] mux_all;
   wire [5:0]   lo_sel;
   wire [5:0]   hi_sel;
   wire [5:0]   grp;
   wire [5:0]   sel_wr;
   wire         idle;
   wire         wr_cmd;
   wire         scan_trig;
   wire [7:0]   chan_pos;
   wire [7:0]   cur_pos;
   wire [7:0]   nxt_pos;
   wire [5:0]   scan_step;
   wire         chan_ok;
   wire         tmr_done;
   reg          tmr_load;
   reg  [31:0]  tmr_ticks;

   assign idle   = (state_reg == S_IDLE);
   assign wr_cmd = wstb_i & (addr_i == `RCS_ADR_CMD) & idle;
   assign sel_wr = wdata_i[5:0];
   assign valid_all[255:240]    = 16'h0000;
   assign scan_grp_all[255:240] = 16'h0000;
   assign mux_all[255:240]      = 16'h0000;

   // joined scan sections form one group around the addressed section
   assign grp = (join_reg[chan_sect_reg] ? (join_reg & mode_reg) : 6'h00) |
                (6'h01 << chan_sect_reg);

   // ========================================================================
   // per-section limits and encode selection
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi = gi + 1)
      begin : g_sect
         rcs_section u_sect
         (
            .cfg_i   (conf_reg[gi*2 +: 2]),
            .close_i (close_reg[gi*40 +: 40]),
            .valid_o (valid_all[gi*40 +: 40]),
            .lo_sel_o(lo_sel[gi]),
            .hi_sel_o(hi_sel[gi])
         );
         assign scan_grp_all[gi*40 +: 40] = {40{grp[gi]}};
         assign mux_all[gi*40 +: 40]      = {40{~mode_reg[gi]}};
      end
   endgenerate

   // ========================================================================
   // channel positions
   assign chan_pos  = ({5'h00, chan_sect_reg} * 8'd40) + {2'h0, chan_idx_reg};
   assign cur_pos   = ({5'h00, scan_sect_reg} * 8'd40) + {2'h0, scan_cur_reg};
   assign nxt_pos   = ({5'h00, scan_sect_reg} * 8'd40) + {2'h0, scan_nxt_reg};
   assign chan_ok   = (chan_sect_reg < 3'h6) & (chan_idx_reg < 6'd40) &
                      valid_all[chan_pos];
   assign scan_step = (scan_cur_reg == scan_last_reg) ? scan_first_reg
                                                      : scan_cur_reg + 6'h01;
   assign scan_trig = armed_reg & idle & ttl_prev_reg[scan_src_reg] &
                      ~ttl_i[scan_src_reg];

   // ========================================================================
   // sequencing
   always @*
   begin
      state_next = state_reg;
      tmr_load   = 1'b0;
      tmr_ticks  = 32'h0000_0000;
      case (state_reg)
         S_IDLE :
         begin
            if (scan_trig)
            begin
               state_next = S_TDLY;
               tmr_load   = 1'b1;
               tmr_ticks  = trig_delay_reg;
            end
            else if (wr_cmd & wdata_i[`RCS_CMD_SCAN_CLOSE] & chan_ok)
               state_next = S_OPEN;
            else if (wr_cmd & wdata_i[`RCS_CMD_MUX_CLOSE])
               state_next = S_CLOSE;
            else if (wr_cmd & wdata_i[`RCS_CMD_OPEN])
               state_next = S_OPEN;
         end
         S_TDLY :
            if (tmr_done)
               state_next = first_reg ? S_CLOSE : S_OPEN;
         S_OPEN :
         begin
            state_next = S_ODW;
            tmr_load   = 1'b1;
            tmr_ticks  = open_dwell_reg;
         end
         S_ODW :
            if (tmr_done)
               state_next = (close_reg == 256'h0) ? S_IDLE : S_CLOSE;
         S_CLOSE :
         begin
            state_next = S_CDW;
            tmr_load   = 1'b1;
            tmr_ticks  = close_dwell_reg;
         end
         S_CDW :
            if (tmr_done)
            begin
               state_next = S_TRIG;
               tmr_load   = 1'b1;
               tmr_ticks  = `RCS_TRIG_TICKS;
            end
         S_TRIG :
            if (tmr_done)
            begin
               state_next = S_ENCW;
               tmr_load   = 1'b1;
               tmr_ticks  = ENC_DLY_TICKS;
            end
         S_ENCW :
            if (tmr_done)
            begin
               state_next = S_ENCL;
               tmr_load   = 1'b1;
               tmr_ticks  = ENC_WID_TICKS;
            end
         S_ENCL :
            if (tmr_done)
               state_next = S_IDLE;
         default :
            state_next = S_IDLE;
      endcase
   end

   rcs_timer u_timer
   (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .load_i (tmr_load),
      .ticks_i(tmr_ticks),
      .done_o (tmr_done)
   );

   // ========================================================================
   // state, relays and strobes
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg    <= S_IDLE;
         relay_reg    <= 256'h0;
         open_reg     <= 256'h0;
         close_reg    <= 256'h0;
         armed_reg    <= 1'b0;
         first_reg    <= 1'b1;
         scan_cur_reg <= 6'h00;
         scan_nxt_reg <= 6'h00;
         ttl_prev_reg <= 8'hff;
         ttl_oe_n_o   <= 8'hff;
         enc_lo_reg   <= 6'h00;
         enc_hi_reg   <= 6'h00;
         enc_lo_n_o   <= 6'h3f;
         enc_hi_n_o   <= 6'h3f;
      end
      else
      begin
         state_reg    <= state_next;
         ttl_prev_reg <= ttl_i;
         if (wr_cmd & wdata_i[`RCS_CMD_ARM])
         begin
            armed_reg <= 1'b1;
            first_reg <= 1'b1;
         end
         else if (wr_cmd & wdata_i[`RCS_CMD_DISARM])
            armed_reg <= 1'b0;
         if (idle)
         begin
            if (scan_trig)
            begin
               open_reg     <= first_reg ? 256'h0 : (256'h1 << cur_pos);
               close_reg    <= 256'h0;
               scan_nxt_reg <= first_reg ? scan_first_reg : scan_step;
            end
            else if (wr_cmd & wdata_i[`RCS_CMD_SCAN_CLOSE] & chan_ok)
            begin
               open_reg  <= scan_grp_all;
               close_reg <= (256'h1 << chan_pos);
            end
            else if (wr_cmd & wdata_i[`RCS_CMD_MUX_CLOSE])
            begin
               open_reg  <= 256'h0;
               close_reg <= mask_reg & valid_all & mux_all;
            end
            else if (wr_cmd & wdata_i[`RCS_CMD_OPEN])
            begin
               open_reg  <= mask_reg;
               close_reg <= 256'h0;
            end
            else if (wstb_i & (addr_i == `RCS_ADR_MODE))
               relay_reg <= relay_reg & ~sel_all(sel_wr);
            else if (wstb_i & (addr_i == `RCS_ADR_CONF))
               relay_reg <= relay_reg & ~sel_all(sel_wr);
         end
         if ((state_reg == S_TDLY) & tmr_done)
            close_reg <= (256'h1 << nxt_pos);
         if (state_reg == S_OPEN)
            relay_reg <= relay_reg & ~open_reg;
         if (state_reg == S_CLOSE)
         begin
            relay_reg  <= relay_reg | close_reg;
            enc_lo_reg <= lo_sel;
            enc_hi_reg <= hi_sel;
            if (~idle & (close_reg == (256'h1 << nxt_pos)))
            begin
               scan_cur_reg <= scan_nxt_reg;
               first_reg    <= 1'b0;
            end
         end
         ttl_oe_n_o <= (state_next == S_TRIG) ? ~ttl_en_reg : 8'hff;
         enc_lo_n_o <= (state_next == S_ENCL) ? ~enc_lo_reg : 6'h3f;
         enc_hi_n_o <= (state_next == S_ENCL) ? ~enc_hi_reg : 6'h3f;
      end
   end

   // expands a section select into channel bits
   function [255:0] sel_all;
      input [5:0] sel;
      integer k;
      begin
         sel_all = 256'h0;
         for (k = 0; k < 240; k = k + 1)
            sel_all[k] = sel[k / 40];
      end
   endfunction

   assign ttl_o      = 8'h00;
   assign relay_on_o = relay_reg[239:0];

   // ========================================================================
   // register writes; mode, configuration and join changes are refused while busy
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         mask_reg        <= 256'h0;
         mode_reg        <= `RCS_RST_MODE;
         conf_reg        <= `RCS_RST_CONF;
         join_reg        <= 6'h00;
         open_dwell_reg  <= `RCS_RST_DWELL;
         close_dwell_reg <= `RCS_RST_DWELL;
         trig_delay_reg  <= `RCS_RST_DWELL;
         ttl_en_reg      <= `RCS_RST_TTL_EN;
         scan_sect_reg   <= 3'h0;
         scan_first_reg  <= 6'h00;
         scan_last_reg   <= 6'h00;
         scan_src_reg    <= 3'h0;
         chan_sect_reg   <= 3'h0;
         chan_idx_reg    <= 6'h00;
         word_idx_reg    <= 3'h0;
      end
      else if (wstb_i)
      begin
         if (addr_i == `RCS_ADR_MODE)
         begin
            if (idle)
               mode_reg <= wdata_i[`RCS_MODE_SCAN_BIT] ? (mode_reg | sel_wr)
                                                       : (mode_reg & ~sel_wr);
         end
         else if (addr_i == `RCS_ADR_CONF)
         begin
            if (idle)
               conf_reg <= conf_sel(conf_reg, sel_wr, wdata_i[`RCS_CONF_LSB +: 2]);
         end
         else if (addr_i == `RCS_ADR_JOIN)
         begin
            if (idle)
               join_reg <= wdata_i[5:0];
         end
         else if (addr_i == `RCS_ADR_OPEN_DWELL)
            open_dwell_reg <= wdata_i;
         else if (addr_i == `RCS_ADR_CLOSE_DWELL)
            close_dwell_reg <= wdata_i;
         else if (addr_i == `RCS_ADR_TRIG_DELAY)
            trig_delay_reg <= wdata_i;
         else if (addr_i == `RCS_ADR_TTL_EN)
            ttl_en_reg <= wdata_i[7:0];
         else if (addr_i == `RCS_ADR_SCAN)
         begin
            scan_sect_reg  <= wdata_i[2:0];
            scan_first_reg <= wdata_i[`RCS_SCAN_FIRST_LSB +: 6];
            scan_last_reg  <= wdata_i[`RCS_SCAN_LAST_LSB +: 6];
            scan_src_reg   <= wdata_i[`RCS_SCAN_SRC_LSB +: 3];
         end
         else if (addr_i == `RCS_ADR_CHAN)
         begin
            chan_sect_reg <= wdata_i[2:0];
            chan_idx_reg  <= wdata_i[`RCS_CHAN_LSB +: 6];
         end
         else if (addr_i == `RCS_ADR_WORD_IDX)
            word_idx_reg <= wdata_i[2:0];
         else if (addr_i == `RCS_ADR_MASK)
            mask_reg[word_idx_reg*32 +: 32] <= wdata_i;
      end
   end

   // replaces the configuration of each selected section
   function [11:0] conf_sel;
      input [11:0] cur;
      input [5:0]  sel;
      input [1:0]  cfg;
      integer j;
      begin
         conf_sel = cur;
         for (j = 0; j < 6; j = j + 1)
            if (sel[j])
               conf_sel[j*2 +: 2] = cfg;
      end
   endfunction

   // ========================================================================
   // register reads, data in the following cycle
   always @(posedge clk_i)
   begin
      if (rst_i)
         rdata_o <= 32'h0000_0000;
      else if (rstb_i)
      begin
         if (addr_i == `RCS_ADR_STATUS)
            rdata_o <= {21'h0, state_reg, armed_reg, ~idle};
         else if (addr_i == `RCS_ADR_MODE)
            rdata_o <= {26'h0, mode_reg};
         else if (addr_i == `RCS_ADR_CONF)
            rdata_o <= {20'h0, conf_reg};
         else if (addr_i == `RCS_ADR_JOIN)
            rdata_o <= {26'h0, join_reg};
         else if (addr_i == `RCS_ADR_OPEN_DWELL)
            rdata_o <= open_dwell_reg;
         else if (addr_i == `RCS_ADR_CLOSE_DWELL)
            rdata_o <= close_dwell_reg;
         else if (addr_i == `RCS_ADR_TRIG_DELAY)
            rdata_o <= trig_delay_reg;
         else if (addr_i == `RCS_ADR_TTL_EN)
            rdata_o <= {24'h0, ttl_en_reg};
         else if (addr_i == `RCS_ADR_SCAN)
            rdata_o <= {5'h0, scan_src_reg, 2'h0, scan_last_reg, 2'h0,
                        scan_first_reg, 5'h0, scan_sect_reg};
         else if (addr_i == `RCS_ADR_CHAN)
            rdata_o <= {18'h0, chan_idx_reg, 5'h0, chan_sect_reg};
         else if (addr_i == `RCS_ADR_WORD_IDX)
            rdata_o <= {29'h0, word_idx_reg};
         else if (addr_i == `RCS_ADR_MASK)
            rdata_o <= mask_reg[word_idx_reg*32 +: 32];
         else if (addr_i == `RCS_ADR_RELAY)
            rdata_o <= relay_reg[word_idx_reg*32 +: 32];
         else
            rdata_o <= 32'h0000_0000;
      end
   end

endmodule // rcs_sequencer

// ---- rcs_regs.vh ----
// register offsets, field positions, reset values and timing counts of the
// relay close sequencer; assumes a 40 MHz clock and byte addresses on the port
`ifndef RCS_REGS_VH
`define RCS_REGS_VH

// ==========================================================================
// register offsets
`define RCS_ADR_CMD        8'h00
`define RCS_ADR_STATUS     8'h04
`define RCS_ADR_MODE       8'h08
`define RCS_ADR_CONF       8'h0c
`define RCS_ADR_JOIN       8'h10
`define RCS_ADR_OPEN_DWELL 8'h14
`define RCS_ADR_CLOSE_DWELL 8'h18
`define RCS_ADR_TRIG_DELAY 8'h1c
`define RCS_ADR_TTL_EN     8'h20
`define RCS_ADR_SCAN       8'h24
`define RCS_ADR_CHAN       8'h28
`define RCS_ADR_WORD_IDX   8'h2c
`define RCS_ADR_MASK       8'h30
`define RCS_ADR_RELAY      8'h34

// ==========================================================================
// command bits
`define RCS_CMD_MUX_CLOSE  0
`define RCS_CMD_SCAN_CLOSE 1
`define RCS_CMD_OPEN       2
`define RCS_CMD_ARM        3
`define RCS_CMD_DISARM     4

// ==========================================================================
// field positions
`define RCS_MODE_SCAN_BIT  8
`define RCS_CONF_LSB       8
`define RCS_SCAN_FIRST_LSB 8
`define RCS_SCAN_LAST_LSB  16
`define RCS_SCAN_SRC_LSB   24
`define RCS_CHAN_LSB       8

// ==========================================================================
// wire configurations
`define RCS_CFG_1W         2'h0
`define RCS_CFG_2W         2'h1
`define RCS_CFG_4W         2'h2
`define RCS_CFG_4W_IND     2'h3

// ==========================================================================
// reset values
`define RCS_RST_MODE       6'h00
`define RCS_RST_CONF       12'h000
`define RCS_RST_DWELL      32'h0000_0000
`define RCS_RST_TTL_EN     8'h00

// ==========================================================================
// timing
`define RCS_CLK_PERIOD_NS  25
`define RCS_TICK_NS        200
`define RCS_TICK_CYC       (`RCS_TICK_NS / `RCS_CLK_PERIOD_NS)
`define RCS_TRIG_PULSE_NS  200
`define RCS_TRIG_TICKS     (`RCS_TRIG_PULSE_NS / `RCS_TICK_NS)
`define RCS_ENC_DLY_MS     5
`define RCS_ENC_WID_MS     4
`define RCS_ENC_DLY_TICKS  (`RCS_ENC_DLY_MS * 1000000 / `RCS_TICK_NS)
`define RCS_ENC_WID_TICKS  (`RCS_ENC_WID_MS * 1000000 / `RCS_TICK_NS)

`endif

// ---- rcs_timer.v ----
// common 200 ns time base and loadable down counter of the sequencer
// assumes load is a one-cycle pulse given on entry to each timed state
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_timer
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // control
   input  wire        load_i,
   input  wire [31:0] ticks_i,
   // status
   output wire        done_o
);

   localparam [31:0] TICK_LAST_W = `RCS_TICK_CYC - 1;
   localparam [2:0]  TICK_LAST   = TICK_LAST_W[2:0];

   reg  [2:0]  pre_reg;
   reg  [31:0] cnt_reg;
   reg         run_reg;
   wire        tick;

   assign tick   = (pre_reg == TICK_LAST);
   // done in the last cycle of the final tick, so n ticks last 8n cycles;
   // not gated by load, the sequencer reloads on done and would loop
   assign done_o = run_reg &
                   ((cnt_reg == 32'h0000_0000) | ((cnt_reg == 32'h0000_0001) & tick));

   // ========================================================================
   // prescaler restarts on load so every delay starts on a tick boundary
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         pre_reg <= 3'h0;
         cnt_reg <= 32'h0000_0000;
         run_reg <= 1'b0;
      end
      else if (load_i)
      begin
         pre_reg <= 3'h0;
         cnt_reg <= ticks_i;
         run_reg <= 1'b1;
      end
      else
      begin
         pre_reg <= tick ? 3'h0 : pre_reg + 3'h1;
         if (done_o)
            run_reg <= 1'b0;
         else if (tick)
            cnt_reg <= cnt_reg - 32'h0000_0001;
      end
   end

endmodule // rcs_timer

// ---- rcs_section.v ----
// per-section channel limits and encode selection
// assumes bit 0 of the channel vector is channel 1 of the section
`timescale 1ns/1ps
`include "rcs_regs.vh"

module rcs_section
(
   // configuration
   input  wire [1:0]  cfg_i,
   // channels being closed
   input  wire [39:0] close_i,
   // results
   output reg  [39:0] valid_o,
   output wire        lo_sel_o,
   output wire        hi_sel_o
);

   wire any_close;
   wire odd_close;
   wire even_close;
   wire indep;

   always @*
   begin
      case (cfg_i)
         `RCS_CFG_1W : valid_o = 40'hff_ffff_ffff;
         `RCS_CFG_2W : valid_o = 40'h00_000f_ffff;
         `RCS_CFG_4W : valid_o = 40'h00_0000_03ff;
         default     : valid_o = 40'h00_000f_ffff;
      endcase
   end

   assign any_close  = |close_i;
   assign odd_close  = |(close_i & 40'h55_5555_5555);
   assign even_close = |(close_i & 40'haa_aaaa_aaaa);
   assign indep      = (cfg_i == `RCS_CFG_4W_IND);

   assign lo_sel_o = indep ? odd_close  : any_close;
   assign hi_sel_o = indep ? even_close : any_close;

endmodule // rcs_section

// ---- rcs_sequencer_sva.sv ----
// port checker of the relay close sequencer
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/1ps
module rcs_sequencer_sva
#(
   parameter [31:0] ENC_DLY_TICKS = 32'h5,
   parameter [31:0] ENC_WID_TICKS = 32'h4
)
(
   // clock, reset and register port
   input wire clk_i, input wire rst_i, input wire [7:0] addr_i, input wire [31:0] wdata_i,
   input wire wstb_i, input wire rstb_i, input wire [31:0] rdata_o,
   // trigger lines, relays and encode strobes
   input wire [7:0] ttl_i, input wire [7:0] ttl_o, input wire [7:0] ttl_oe_n_o,
   input wire [239:0] relay_on_o, input wire [5:0] enc_lo_n_o, input wire [5:0] enc_hi_n_o
);
   localparam int DLYC = ENC_DLY_TICKS * 8 - 7;
   localparam int WIDC = ENC_WID_TICKS * 8 - 9;
   wire [11:0] enc  = {enc_hi_n_o, enc_lo_n_o};
   wire        trig = ttl_oe_n_o != 8'hff;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_trig_width; !$past(trig) && trig |=> $stable(ttl_oe_n_o)[*7] ##1 !trig; endproperty
   a_trig_width: assert property (p_trig_width) else $error("bad trigger width");
   property p_enc_delay; $fell(trig) |-> (&enc)[*8] ##DLYC !(&enc); endproperty
   a_enc_delay: assert property (p_enc_delay) else $error("bad encode delay");
   property p_enc_width; $fell(&enc) |=> $stable(enc)[*8] ##WIDC !(&enc) ##1 (&enc); endproperty
   a_enc_width: assert property (p_enc_width) else $error("bad encode width");
   property p_enc_order; trig |-> &enc; endproperty
   a_enc_order: assert property (p_enc_order) else $error("encode during trigger");
   property p_relay_hold; trig || !(&enc) |-> $stable(relay_on_o); endproperty
   a_relay_hold: assert property (p_relay_hold) else $error("relay moved in pulses");
   property p_open_gap;
      |($past(relay_on_o) & ~relay_on_o) |-> !(|(relay_on_o & ~$past(relay_on_o)))[*2];
   endproperty
   a_open_gap: assert property (p_open_gap) else $error("close without open dwell");
   property p_ttl_low; ttl_o == 8'h00; endproperty
   a_ttl_low: assert property (p_ttl_low) else $error("trigger drive not low");
   property p_quiet; $fell(rst_i) |-> relay_on_o == '0 && !trig && (&enc); endproperty
   a_quiet: assert property (p_quiet) else $error("outputs not quiet after reset");
   property p_unmapped; rstb_i && addr_i == 8'h3c |=> rdata_o == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   c_trig: cover property (!$past(trig) && trig);
   c_enc: cover property ($fell(&enc));
   c_open: cover property (|($past(relay_on_o) & ~relay_on_o));
endmodule // rcs_sequencer_sva

bind rcs_sequencer rcs_sequencer_sva
   #(.ENC_DLY_TICKS(ENC_DLY_TICKS), .ENC_WID_TICKS(ENC_WID_TICKS))
   i_rcs_sequencer_sva (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
   .wstb_i(wstb_i), .rstb_i(rstb_i), .rdata_o(rdata_o), .ttl_i(ttl_i), .ttl_o(ttl_o),
   .ttl_oe_n_o(ttl_oe_n_o), .relay_on_o(relay_on_o), .enc_lo_n_o(enc_lo_n_o),
   .enc_hi_n_o(enc_hi_n_o));

// ---- rcs_ttl_model.sv ----
// backplane trigger lines: open drain with pull-up, plus an external pulser
// assumes the sequencer sinks a line only through its active-low enable
`timescale 1ns/1ps
module rcs_ttl_model
(
   // sequencer side
   input  wire logic [7:0] drv_i,
   input  wire logic [7:0] oe_n_i,
   // external trigger source and wire level
   input  wire logic [7:0] pull_i,
   output wire logic [7:0] line_o
);
   // pull-up wins unless someone sinks the line
   assign line_o = ~pull_i & (oe_n_i | drv_i);
endmodule // rcs_ttl_model

// ---- tb.sv ----
// self-checking bench of the relay close sequencer
// assumes the trigger line model and the bound port checker
`timescale 1ns/1ps
module tb;
   logic         clk_i = 1'b0, rst_i = 1'b1, wstb_i = 1'b0, rstb_i = 1'b0;
   logic [7:0]   addr_i = 8'h00, pull = 8'h00, pt, oe;
   logic [31:0]  wdata_i = 32'h0, cnt, dw, d;
   logic [11:0]  en;
   logic [239:0] prev, e;
   wire  [7:0]   ttl_i, ttl_o, ttl_oe_n_o;
   wire  [31:0]  rdata_o;
   wire  [239:0] relay_on_o;
   wire  [5:0]   enc_lo_n_o, enc_hi_n_o;
   int           err_count = 0;
   int           cmp_count = 0;
   rcs_sequencer #(.ENC_DLY_TICKS(32'h5), .ENC_WID_TICKS(32'h4)) i_rcs_sequencer (.clk_i(clk_i),
      .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wstb_i(wstb_i), .rstb_i(rstb_i),
      .rdata_o(rdata_o), .ttl_i(ttl_i), .ttl_o(ttl_o), .ttl_oe_n_o(ttl_oe_n_o),
      .relay_on_o(relay_on_o), .enc_lo_n_o(enc_lo_n_o), .enc_hi_n_o(enc_hi_n_o));
   rcs_ttl_model i_rcs_ttl_model (.drv_i(ttl_o), .oe_n_i(ttl_oe_n_o), .pull_i(pull),
      .line_o(ttl_i));
   initial forever #12.5 clk_i = ~clk_i;
   // ======================================================================
   // monitor: dwell from last closure to trigger, trigger and encode patterns
   always @(posedge clk_i)
   begin
      cnt  <= |(relay_on_o & ~prev) ? 32'h0 : cnt + 32'h1;
      prev <= relay_on_o;
      pt   <= ttl_oe_n_o;
      if (ttl_oe_n_o != 8'hff && pt == 8'hff)
      begin
         dw <= cnt;
         oe <= ttl_oe_n_o;
      end
      if ({enc_hi_n_o, enc_lo_n_o} != 12'hfff)
         en <= {enc_hi_n_o, enc_lo_n_o};
   end
   // ======================================================================
   // bus tasks and checks
   task automatic chk(input logic [239:0] g, input logic [239:0] x);
      cmp_count++;
      if (g !== x)
      begin
         err_count++;
         $display("MISMATCH %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wstb_i  <= 1'b1;
      @(posedge clk_i);
      wstb_i  <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rstb_i <= 1'b1;
      @(posedge clk_i);
      rstb_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   task automatic idle;
      d = 32'h1;
      repeat (400) if (d[0] !== 1'b0) rd(8'h04, d);
   endtask
   task automatic pause;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic kick;
      @(posedge clk_i);
      pull <= 8'h08;
      repeat (2) @(posedge clk_i);
      pull <= 8'h00;
   endtask
   task automatic close_out;
      $display("errors %0d compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #200us;
      err_count++;
      close_out;
   end
   initial
   begin
      e = (240'h1 << 79) | (240'h1 << 120);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(8'h08, d);
      chk(d, 240'h0);
      rd(8'h3c, d);
      chk(d, 240'h0);
      wr(8'h08, 32'h13f);
      wr(8'h10, 32'h3);
      wr(8'h14, 32'h2);
      wr(8'h18, 32'h3);
      wr(8'h1c, 32'h1);
      wr(8'h20, 32'h81);
      wr(8'h00, 32'h2);
      idle;
      chk(relay_on_o, 240'h1);
      chk({dw, oe, en}, {32'd23, 8'h7e, 12'hfbe});
      wr(8'h28, 32'h2701);
      wr(8'h00, 32'h2);
      idle;
      chk(relay_on_o, 240'h1 << 79);
      wr(8'h28, 32'h2802);
      wr(8'h00, 32'h2);
      pause;
      chk(relay_on_o, 240'h1 << 79);
      wr(8'h08, 32'h00c);
      wr(8'h0c, 32'h308);
      wr(8'h30, 32'h20);
      wr(8'h2c, 32'h2);
      wr(8'h30, 32'h3_0000);
      wr(8'h2c, 32'h3);
      wr(8'h30, 32'h0100_0000);
      wr(8'h2c, 32'h4);
      wr(8'h30, 32'h1000);
      wr(8'h00, 32'h1);
      idle;
      chk(relay_on_o, e | (240'h3 << 80));
      chk({dw, oe, en}, {32'd23, 8'h7e, 12'hef3});
      wr(8'h0c, 32'h104);
      pause;
      chk(relay_on_o, e);
      wr(8'h24, 32'h0301_0004);
      kick;
      pause;
      chk(relay_on_o, e);
      wr(8'h00, 32'h8);
      kick;
      idle;
      chk(relay_on_o, e | (240'h1 << 160));
      kick;
      idle;
      chk(relay_on_o, e | (240'h1 << 161));
      wr(8'h00, 32'h10);
      wr(8'h08, 32'h110);
      pause;
      chk(relay_on_o, e);
      kick;
      idle;
      chk(relay_on_o, e);
      wr(8'h00, 32'h4);
      idle;
      chk(relay_on_o, 240'h1 << 79);
      close_out;
   end
endmodule // tb
